// *** pkg/gpio_bank_pkg.sv ***
/*
 * Constants for the general-purpose pin bank: register offsets, field
 * layout, reset values and pin numbering.
 * Assumes a 16-bit register port addressed by the printed offsets.
 */
package gpio_bank_pkg;

	// ***************************************************************
	// Widths
	// ***************************************************************
	localparam int ADDR_W    = 16;
	localparam int DATA_W    = 16;
	localparam int NUM_PINS  = 17;
	localparam int LOW_PINS  = 16;
	localparam int CFG_W     = 15;
	localparam int HIGH_BIT  = 0;

	// ***************************************************************
	// Register offsets
	// ***************************************************************
	localparam logic [15:0] OFF_INPUT_LEVEL_LOW    = 16'h4700;
	localparam logic [15:0] OFF_INPUT_LEVEL_HIGH   = 16'h4702;
	localparam logic [15:0] OFF_OUTPUT_LEVEL_HIGH  = 16'h4704;
	localparam logic [15:0] OFF_OUTPUT_LEVEL_LOW   = 16'h4706;
	localparam logic [15:0] OFF_OUTPUT_SET_HIGH    = 16'h4708;
	localparam logic [15:0] OFF_OUTPUT_SET_LOW     = 16'h470a;
	localparam logic [15:0] OFF_OUTPUT_CLEAR_HIGH  = 16'h470c;
	localparam logic [15:0] OFF_OUTPUT_CLEAR_LOW   = 16'h470e;
	localparam logic [15:0] OFF_PIN_CONFIGURATION  = 16'h4712;
	localparam logic [15:0] OFF_DIRECTION_HIGH     = 16'h4714;
	localparam logic [15:0] OFF_DIRECTION_LOW      = 16'h4716;
	localparam logic [15:0] OFF_DIRECTION_SET_HIGH = 16'h4718;

	// ***************************************************************
	// Reset values
	// ***************************************************************
	localparam logic [14:0] CFG_RESET      = 15'h2000;
	localparam logic [15:0] LOW_RESET      = 16'h0000;
	localparam logic        HIGH_RESET     = 1'b0;
	localparam logic [15:0] RDATA_IDLE     = 16'h0000;
	localparam logic [16:0] PINS_RESET     = 17'h0_0000;

	// ***************************************************************
	// Two-wire serial bus pins, open-drain under their alternate use
	// ***************************************************************
	localparam int SDA_PIN = 1;
	localparam int SCL_PIN = 2;

endpackage

// *** hw/pin_sync.sv ***
/*
 * Two-flop synchroniser for a group of pin inputs.
 * Assumes the inputs are asynchronous to clk; only the second stage is
 * read outside this module.
 */
`timescale 1ns/1ns

module pin_sync
#(
	parameter int WIDTH = 1
)
(
	// Clock and reset
	input  wire logic             clk,
	input  wire logic             rst_sync_b,
	// Levels
	input  wire logic [WIDTH-1:0] async_in,
	output      logic [WIDTH-1:0] sync_out
);

	logic [WIDTH-1:0] meta_r;

	// First stage is read by the second stage only
	always_ff @(posedge clk or negedge rst_sync_b)
	begin
		if (!rst_sync_b)
		begin
			meta_r   <= '0;
			sync_out <= '0;
		end
		else
		begin
			meta_r   <= async_in;
			sync_out <= meta_r;
		end
	end

endmodule

// *** hw/gpio_data_direction_bank.sv ***
/*
 * Register bank of a 17-pin general-purpose port: pin configuration,
 * sampled input levels, output latch with set and clear strobes, and
 * direction latch with a set strobe for the top pin.
 * Assumes a register master on clk, asynchronous pin inputs, and an
 * outside decoder that turns the configuration mode into alt_en.
 */

// How it works
// RULE1: Low input register reads synchronised pins 0-15
// RULE2: High input register bit 0 is pin 16
// RULE3: Output latch is read/write, reads latch not pin
// RULE4: Low set strobe sets latch bits written one
// RULE5: High set strobe bit 0 sets pin 16
// RULE6: Low clear strobe clears latch bits written one
// RULE7: High clear strobe bit 0 clears pin 16
// RULE8: Direction latch read/write; one enables the driver
// RULE9: High direction set bit 0 enables pin 16
// RULE10: Alternate outputs push-pull except two-wire pins
// RULE11: Fifteen-bit mode field, resets to 0x2000
// RULE12: Reset clears latches; strobe registers read zero

`timescale 1ns/1ns

module gpio_data_direction_bank
	import gpio_bank_pkg::*;
(
	// Clock and reset
	input  wire logic                clk,
	input  wire logic                rst_b,
	// Register port
	input  wire logic [ADDR_W-1:0]   reg_addr,
	input  wire logic [DATA_W-1:0]   reg_wdata,
	input  wire logic                reg_wr,
	input  wire logic                reg_rd,
	output      logic [DATA_W-1:0]   reg_rdata,
	// Package pins
	input  wire logic [NUM_PINS-1:0] pin_in,
	output      logic [NUM_PINS-1:0] pin_out,
	output      logic [NUM_PINS-1:0] pin_oe,
	// Alternate peripheral functions
	input  wire logic [NUM_PINS-1:0] alt_en,
	input  wire logic [NUM_PINS-1:0] alt_out,
	input  wire logic [NUM_PINS-1:0] alt_oe,
	output      logic [NUM_PINS-1:0] alt_in,
	output      logic [CFG_W-1:0]    cfg_mode
);

	// ***************************************************************
	// Helpers
	// ***************************************************************

	// Full-address match, shared by every write decode; the read path decodes with a case
	function automatic logic hit(input logic [ADDR_W-1:0] addr,
	                             input logic [ADDR_W-1:0] offs);
		hit = (addr == offs);
	endfunction

	// Apply a write-one-to-set or write-one-to-clear strobe
	function automatic logic [LOW_PINS-1:0] w1_apply(
		input logic [LOW_PINS-1:0] cur,
		input logic [LOW_PINS-1:0] mask,
		input logic                set);
		if (set)
			w1_apply = cur | mask;
		else
			w1_apply = cur & ~mask;
	endfunction

	// One-bit form for the pin-16 strobes; a zero leaves the bit alone
	function automatic logic w1_bit(
		input logic cur,
		input logic strobe,
		input logic set);
		if (strobe)
			w1_bit = set;
		else
			w1_bit = cur;
	endfunction

	// ***************************************************************
	// Reset release
	// ***************************************************************
	logic rst_meta_b_r;
	logic rst_sync_b;

	// Asserts at once, releases two edges later
	always_ff @(posedge clk or negedge rst_b)
	begin
		if (!rst_b)
		begin
			rst_meta_b_r <= 1'b0;
			rst_sync_b   <= 1'b0;
		end
		else
		begin
			rst_meta_b_r <= 1'b1;
			rst_sync_b   <= rst_meta_b_r;
		end
	end

	// ***************************************************************
	// Pin input sampling
	// ***************************************************************
	logic [NUM_PINS-1:0] pin_level;

	pin_sync
	#(
		.WIDTH (NUM_PINS)
	)
	u_pin_sync
	(
		.clk        (clk),
		.rst_sync_b (rst_sync_b),
		.async_in   (pin_in),
		.sync_out   (pin_level)
	);

	// Peripherals see the same sampled level as software
	assign alt_in = pin_level;

	// ***************************************************************
	// Write decode
	// ***************************************************************
	logic wr_out_low;
	logic wr_out_high;
	logic wr_set_low;
	logic wr_set_high;
	logic wr_clr_low;
	logic wr_clr_high;
	logic wr_cfg;
	logic wr_dir_low;
	logic wr_dir_high;
	logic wr_dirset_high;

	assign wr_out_low     = reg_wr && hit(reg_addr, OFF_OUTPUT_LEVEL_LOW);
	assign wr_out_high    = reg_wr && hit(reg_addr, OFF_OUTPUT_LEVEL_HIGH);
	assign wr_set_low     = reg_wr && hit(reg_addr, OFF_OUTPUT_SET_LOW);
	assign wr_set_high    = reg_wr && hit(reg_addr, OFF_OUTPUT_SET_HIGH);
	assign wr_clr_low     = reg_wr && hit(reg_addr, OFF_OUTPUT_CLEAR_LOW);
	assign wr_clr_high    = reg_wr && hit(reg_addr, OFF_OUTPUT_CLEAR_HIGH);
	assign wr_cfg         = reg_wr && hit(reg_addr, OFF_PIN_CONFIGURATION);
	assign wr_dir_low     = reg_wr && hit(reg_addr, OFF_DIRECTION_LOW);
	assign wr_dir_high    = reg_wr && hit(reg_addr, OFF_DIRECTION_HIGH);
	assign wr_dirset_high = reg_wr && hit(reg_addr, OFF_DIRECTION_SET_HIGH);

	// ***************************************************************
	// Pin configuration
	// ***************************************************************
	logic [CFG_W-1:0] cfg_r;

	always_ff @(posedge clk or negedge rst_sync_b)
	begin
		if (!rst_sync_b)
			cfg_r <= CFG_RESET; // RULE11
		else if (wr_cfg)
			cfg_r <= reg_wdata[CFG_W-1:0]; // RULE11
	end

	// Decoding to alternate functions lives outside; pulls are untouched
	assign cfg_mode = cfg_r;

	// ***************************************************************
	// Output latch, pins 0-15
	// ***************************************************************
	logic [LOW_PINS-1:0] out_low_r;
	logic [LOW_PINS-1:0] out_low_nxt;

	always_comb
	begin
		out_low_nxt = out_low_r;
		if (wr_out_low)
			out_low_nxt = reg_wdata[LOW_PINS-1:0]; // RULE3
		else if (wr_set_low)
			out_low_nxt = w1_apply(out_low_r,
			                       reg_wdata[LOW_PINS-1:0], 1'b1); // RULE4
		else if (wr_clr_low)
			out_low_nxt = w1_apply(out_low_r,
			                       reg_wdata[LOW_PINS-1:0], 1'b0); // RULE6
	end

	always_ff @(posedge clk or negedge rst_sync_b)
	begin
		if (!rst_sync_b)
			out_low_r <= LOW_RESET; // RULE12
		else
			out_low_r <= out_low_nxt;
	end

	// ***************************************************************
	// Output latch, pin 16
	// ***************************************************************
	logic out_high_r;
	logic out_high_nxt;

	always_comb
	begin
		out_high_nxt = out_high_r;
		if (wr_out_high)
			out_high_nxt = reg_wdata[HIGH_BIT]; // RULE3
		else if (wr_set_high)
			out_high_nxt = w1_bit(out_high_r,
			                      reg_wdata[HIGH_BIT], 1'b1); // RULE5
		else if (wr_clr_high)
			out_high_nxt = w1_bit(out_high_r,
			                      reg_wdata[HIGH_BIT], 1'b0); // RULE7
	end

	always_ff @(posedge clk or negedge rst_sync_b)
	begin
		if (!rst_sync_b)
			out_high_r <= HIGH_RESET; // RULE12
		else
			out_high_r <= out_high_nxt;
	end

	// ***************************************************************
	// Direction latch
	// ***************************************************************
	logic [LOW_PINS-1:0] dir_low_r;
	logic                dir_high_r;

	always_ff @(posedge clk or negedge rst_sync_b)
	begin
		if (!rst_sync_b)
			dir_low_r <= LOW_RESET; // RULE12
		else if (wr_dir_low)
			dir_low_r <= reg_wdata[LOW_PINS-1:0]; // RULE8
	end

	always_ff @(posedge clk or negedge rst_sync_b)
	begin
		if (!rst_sync_b)
			dir_high_r <= HIGH_RESET; // RULE12
		else if (wr_dir_high)
			dir_high_r <= reg_wdata[HIGH_BIT]; // RULE8
		else if (wr_dirset_high)
			dir_high_r <= w1_bit(dir_high_r,
			                     reg_wdata[HIGH_BIT], 1'b1); // RULE9
	end

	// ***************************************************************
	// Pin drivers
	// ***************************************************************
	logic [NUM_PINS-1:0] latch_out;
	logic [NUM_PINS-1:0] latch_oe;
	logic [NUM_PINS-1:0] pin_out_nxt;
	logic [NUM_PINS-1:0] pin_oe_nxt;

	assign latch_out = {out_high_r, out_low_r};
	assign latch_oe  = {dir_high_r, dir_low_r}; // RULE8

	genvar gi;
	generate
		for (gi = 0; gi < NUM_PINS; gi++)
		begin : g_pin
			if (gi == SDA_PIN || gi == SCL_PIN)
			begin : g_open_drain
				// Under alt_en bus pins only pull low; the line idles high
				always_comb
				begin
					if (alt_en[gi])
					begin
						pin_out_nxt[gi] = 1'b0; // RULE10
						pin_oe_nxt[gi]  = alt_oe[gi] & ~alt_out[gi];
					end
					else
					begin
						pin_out_nxt[gi] = latch_out[gi];
						pin_oe_nxt[gi]  = latch_oe[gi];
					end
				end
			end
			else
			begin : g_push_pull
				always_comb
				begin
					if (alt_en[gi])
					begin
						pin_out_nxt[gi] = alt_out[gi]; // RULE10
						pin_oe_nxt[gi]  = alt_oe[gi];
					end
					else
					begin
						pin_out_nxt[gi] = latch_out[gi];
						pin_oe_nxt[gi]  = latch_oe[gi];
					end
				end
			end
		end
	endgenerate

	// Registered so the pads see no decode glitches, at one cycle cost
	always_ff @(posedge clk or negedge rst_sync_b)
	begin
		if (!rst_sync_b)
		begin
			pin_out <= PINS_RESET;
			pin_oe  <= PINS_RESET; // RULE12
		end
		else
		begin
			pin_out <= pin_out_nxt;
			pin_oe  <= pin_oe_nxt;
		end
	end

	// ***************************************************************
	// Read path
	// ***************************************************************
	logic [DATA_W-1:0] rdata_nxt;

	always_comb
	begin
		rdata_nxt = RDATA_IDLE;
		case (reg_addr)
			OFF_INPUT_LEVEL_LOW:
				rdata_nxt = pin_level[LOW_PINS-1:0]; // RULE1
			OFF_INPUT_LEVEL_HIGH:
				rdata_nxt[HIGH_BIT] = pin_level[LOW_PINS]; // RULE2
			OFF_OUTPUT_LEVEL_LOW:
				rdata_nxt = out_low_r; // RULE3
			OFF_OUTPUT_LEVEL_HIGH:
				rdata_nxt[HIGH_BIT] = out_high_r; // RULE3
			OFF_PIN_CONFIGURATION:
				rdata_nxt[CFG_W-1:0] = cfg_r; // RULE11
			OFF_DIRECTION_LOW:
				rdata_nxt = dir_low_r; // RULE8
			OFF_DIRECTION_HIGH:
				rdata_nxt[HIGH_BIT] = dir_high_r; // RULE8
			// Strobe registers and unmapped offsets read zero
			default:
				rdata_nxt = RDATA_IDLE; // RULE12
		endcase
	end

	// Data valid only in the cycle after the read strobe
	always_ff @(posedge clk or negedge rst_sync_b)
	begin
		if (!rst_sync_b)
			reg_rdata <= RDATA_IDLE;
		else if (reg_rd)
			reg_rdata <= rdata_nxt;
		else
			reg_rdata <= RDATA_IDLE;
	end

endmodule

// *** verif/gpio_bank_sva.sv ***
/* Port checker for the pin bank.
   Assumes the bank top as bind target; alt_en low around latch writes. */
`timescale 1ns/1ns

module gpio_bank_sva
	import gpio_bank_pkg::*;
(
	// Clock and reset
	input wire logic                clk,
	input wire logic                rst_b,
	// Register port
	input wire logic [ADDR_W-1:0]   reg_addr,
	input wire logic [DATA_W-1:0]   reg_wdata,
	input wire logic                reg_wr,
	input wire logic                reg_rd,
	input wire logic [DATA_W-1:0]   reg_rdata,
	// Pins and alternate functions
	input wire logic [NUM_PINS-1:0] pin_in,
	input wire logic [NUM_PINS-1:0] pin_out,
	input wire logic [NUM_PINS-1:0] pin_oe,
	input wire logic [NUM_PINS-1:0] alt_en,
	input wire logic [NUM_PINS-1:0] alt_out,
	input wire logic [NUM_PINS-1:0] alt_oe
);
	// Follows the bank's internal two-edge reset release
	logic rst_d1_r;
	logic rst_d2_r;

	always_ff @(posedge clk or negedge rst_b)
	begin
		if (!rst_b)
		begin
			rst_d1_r <= 1'b0;
			rst_d2_r <= 1'b0;
		end
		else
		begin
			rst_d1_r <= 1'b1;
			rst_d2_r <= rst_d1_r;
		end
	end

	// ****************************************
	// Properties
	// ****************************************
	default clocking @(posedge clk); endclocking
	default disable iff (!rst_d2_r);

	strobe_zero_a:
	assert property (reg_rd && (reg_addr == OFF_OUTPUT_SET_LOW
		|| reg_addr == OFF_OUTPUT_CLEAR_LOW) |=> reg_rdata == 16'h0000)
		else $error("strobe register read not zero");
	in_low_a:
	assert property ($stable(pin_in)[*3] ##0 reg_rd
		&& reg_addr == OFF_INPUT_LEVEL_LOW
		|=> reg_rdata == $past(pin_in[15:0]))
		else $error("low input level mismatch");
	in_high_a:
	assert property ($stable(pin_in)[*3] ##0 reg_rd
		&& reg_addr == OFF_INPUT_LEVEL_HIGH
		|=> reg_rdata == {15'h0000, $past(pin_in[16])})
		else $error("high input level mismatch");
	set_low_a:
	assert property (reg_wr && reg_addr == OFF_OUTPUT_SET_LOW
		&& alt_en == '0 ##1 alt_en == '0 |=> pin_out[15:0]
		== ($past(pin_out[15:0]) | $past(reg_wdata, 2)))
		else $error("low set strobe wrong");
	clear_low_a:
	assert property (reg_wr && reg_addr == OFF_OUTPUT_CLEAR_LOW
		&& alt_en == '0 ##1 alt_en == '0 |=> pin_out[15:0]
		== ($past(pin_out[15:0]) & ~$past(reg_wdata, 2)))
		else $error("low clear strobe wrong");
	set_high_a:
	assert property (reg_wr && reg_addr == OFF_OUTPUT_SET_HIGH
		&& alt_en == '0 ##1 alt_en == '0 |=> pin_out[16]
		== ($past(pin_out[16]) | $past(reg_wdata[0], 2)))
		else $error("high set strobe wrong");
	clear_high_a:
	assert property (reg_wr && reg_addr == OFF_OUTPUT_CLEAR_HIGH
		&& alt_en == '0 ##1 alt_en == '0 |=> pin_out[16]
		== ($past(pin_out[16]) & !$past(reg_wdata[0], 2)))
		else $error("high clear strobe wrong");
	dir_set_a:
	assert property (reg_wr && reg_addr == OFF_DIRECTION_SET_HIGH
		&& alt_en == '0 ##1 alt_en == '0 |=> pin_oe[16]
		== ($past(pin_oe[16]) | $past(reg_wdata[0], 2)))
		else $error("direction set strobe wrong");
	alt_push_a:
	assert property (alt_en[0] |=> pin_out[0] == $past(alt_out[0])
		&& pin_oe[0] == $past(alt_oe[0]))
		else $error("alternate push-pull drive wrong");
	alt_drain_a:
	assert property (alt_en[1] |=> !pin_out[1]
		&& pin_oe[1] == ($past(alt_oe[1]) && !$past(alt_out[1])))
		else $error("two-wire pin not open drain");
endmodule

bind gpio_data_direction_bank gpio_bank_sva gpio_bank_sva_inst (
	.clk(clk), .rst_b(rst_b), .reg_addr(reg_addr),
	.reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
	.reg_rdata(reg_rdata), .pin_in(pin_in), .pin_out(pin_out),
	.pin_oe(pin_oe), .alt_en(alt_en), .alt_out(alt_out), .alt_oe(alt_oe)
);

// *** verif/pin_world.sv ***
/* Package pins seen from outside the bank.
   Assumes pin_oe high while the bank drives; undriven pins are pulled
   to ext_level. */
`timescale 1ns/1ns

module pin_world
	import gpio_bank_pkg::*;
(
	// Bank drive
	input  wire logic [NUM_PINS-1:0] pin_out,
	input  wire logic [NUM_PINS-1:0] pin_oe,
	// Outside pull level
	input  wire logic [NUM_PINS-1:0] ext_level,
	output      logic [NUM_PINS-1:0] pin_in
);
	// ****************************************
	// Wire level
	// ****************************************
	assign pin_in = (pin_oe & pin_out) | (~pin_oe & ext_level);
endmodule

// *** verif/tb.sv ***
/* Register-level testbench of the pin bank.
   Assumes one-cycle strobes and read data in the cycle after reg_rd. */
`timescale 1ns/1ns

module tb;
	import gpio_bank_pkg::*;
	logic        clk;
	logic        rst_b;
	logic        reg_wr;
	logic        reg_rd;
	logic [15:0] reg_addr;
	logic [15:0] reg_wdata;
	logic [15:0] reg_rdata;
	logic [16:0] pin_in, pin_out, pin_oe, alt_in, ext_level;
	logic [16:0] alt_en, alt_out, alt_oe;
	logic [14:0] cfg_mode;
	int          bad_count = 0;
	int          cmp_count = 0;

	// ****************************************
	// Harness
	// ****************************************
	gpio_data_direction_bank gpio_data_direction_bank_inst (
		.clk(clk), .rst_b(rst_b), .reg_addr(reg_addr),
		.reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
		.reg_rdata(reg_rdata), .pin_in(pin_in), .pin_out(pin_out),
		.pin_oe(pin_oe), .alt_en(alt_en), .alt_out(alt_out),
		.alt_oe(alt_oe), .alt_in(alt_in), .cfg_mode(cfg_mode));
	pin_world pin_world_inst (.pin_out(pin_out), .pin_oe(pin_oe),
		.ext_level(ext_level), .pin_in(pin_in));

	initial
	begin
		clk = 1'b0;
		forever #2 clk = ~clk;
	end

	task automatic check(input logic [16:0] got, input logic [16:0] exp);
		cmp_count++;
		if (got !== exp)
		begin
			bad_count++;
			$display("ERROR %0t got %h expected %h", $time, got, exp);
		end
	endtask

	task automatic wr(input logic [15:0] a, input logic [15:0] d);
		@(posedge clk);
		reg_wr <= 1'b1;
		reg_addr <= a;
		reg_wdata <= d;
		@(posedge clk);
		reg_wr <= 1'b0;
	endtask

	// Read data only stand in the cycle after the strobe
	task automatic rd(input logic [15:0] a, input logic [15:0] e);
		@(posedge clk);
		reg_rd <= 1'b1;
		reg_addr <= a;
		@(posedge clk);
		reg_rd <= 1'b0;
		#1 check({1'b0, reg_rdata}, {1'b0, e});
	endtask

	task automatic results;
		if (bad_count == 0 && cmp_count > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask

	// ****************************************
	// Tests
	// ****************************************
	initial
	begin
		{rst_b, reg_wr, reg_rd} = 3'h0;
		{reg_addr, reg_wdata} = 32'h0000_0000;
		{alt_en, alt_out, alt_oe} = 51'h0;
		ext_level = 17'h0_3C5A;
		repeat (8) @(posedge clk);
		rst_b <= 1'b1;
		repeat (3) @(posedge clk);
		#1 check(pin_oe, 17'h0_0000);
		check({2'b00, cfg_mode}, 17'h0_2000);
		rd(OFF_OUTPUT_LEVEL_LOW, 16'h0000);
		rd(OFF_DIRECTION_LOW, 16'h0000);
		rd(OFF_PIN_CONFIGURATION, 16'h2000);
		wr(OFF_PIN_CONFIGURATION, 16'hFFFF);
		rd(OFF_PIN_CONFIGURATION, 16'h7FFF);
		wr(OFF_OUTPUT_LEVEL_LOW, 16'h00F0);
		wr(OFF_OUTPUT_SET_LOW, 16'h0F01);
		rd(OFF_OUTPUT_SET_LOW, 16'h0000);
		rd(OFF_OUTPUT_LEVEL_LOW, 16'h0FF1);
		wr(OFF_OUTPUT_CLEAR_LOW, 16'h00F1);
		rd(OFF_OUTPUT_CLEAR_LOW, 16'h0000);
		rd(OFF_OUTPUT_LEVEL_LOW, 16'h0F00);
		wr(OFF_OUTPUT_LEVEL_HIGH, 16'hFFFF);
		rd(OFF_OUTPUT_LEVEL_HIGH, 16'h0001);
		wr(OFF_OUTPUT_SET_HIGH, 16'hFFFE);
		wr(OFF_OUTPUT_CLEAR_HIGH, 16'h0001);
		rd(OFF_OUTPUT_LEVEL_HIGH, 16'h0000);
		wr(OFF_OUTPUT_SET_HIGH, 16'h0001);
		wr(OFF_OUTPUT_CLEAR_HIGH, 16'hFFFE);
		rd(OFF_OUTPUT_LEVEL_HIGH, 16'h0001);
		wr(OFF_DIRECTION_LOW, 16'hA5A5);
		rd(OFF_DIRECTION_LOW, 16'hA5A5);
		wr(OFF_DIRECTION_SET_HIGH, 16'hFFFE);
		rd(OFF_DIRECTION_HIGH, 16'h0000);
		wr(OFF_DIRECTION_SET_HIGH, 16'h0001);
		rd(OFF_DIRECTION_SET_HIGH, 16'h0000);
		rd(OFF_DIRECTION_HIGH, 16'h0001);
		check(pin_oe, 17'h1_A5A5);
		check(pin_out, 17'h1_0F00);
		// Driven pins read their own drive, the rest the pull level
		wr(OFF_INPUT_LEVEL_LOW, 16'h0000);
		rd(OFF_INPUT_LEVEL_LOW, 16'h1D5A);
		rd(OFF_INPUT_LEVEL_HIGH, 16'h0001);
		check(alt_in, 17'h1_1D5A);
		rd(16'h4710, 16'h0000);
		@(posedge clk);
		alt_en <= 17'h0_0007;
		alt_out <= 17'h0_0005;
		alt_oe <= 17'h0_0003;
		repeat (2) @(posedge clk);
		#1 check(pin_out, 17'h1_0F01);
		check(pin_oe, 17'h1_A5A3);
		@(posedge clk);
		rst_b <= 1'b0;
		#1 check(pin_oe, 17'h0_0000);
		check(pin_out, 17'h0_0000);
		check({2'b00, cfg_mode}, 17'h0_2000);
		repeat (2) @(posedge clk);
		rst_b <= 1'b1;
		repeat (3) @(posedge clk);
		rd(OFF_OUTPUT_LEVEL_LOW, 16'h0000);
		rd(OFF_DIRECTION_HIGH, 16'h0000);
		rd(OFF_PIN_CONFIGURATION, 16'h2000);
		results();
	end

	// Whole sequence needs well under 10000 cycles
	initial
	begin
		#40000;
		bad_count++;
		results();
	end
endmodule
